// *** hdl/vram_pkg.sv ***
package vram_pkg;

  // Cycle kind chosen at the row strobe fall
  typedef enum logic [3:0] {
    MD_CBR  = 4'b0000,
    MD_RW   = 4'b0001,
    MD_RWM  = 4'b0010,
    MD_FWM  = 4'b0011,
    MD_LCR  = 4'b0100,
    MD_RT   = 4'b0101,
    MD_SRT  = 4'b0110,
    MD_MWT  = 4'b0111,
    MD_MSWT = 4'b1000
  } mode_t;

  // Command handed to the array engine
  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_READ    = 3'b001,
    OP_WRITE   = 3'b010,
    OP_BLOCK   = 3'b011,
    OP_FLASH   = 3'b100,
    OP_RD_XFER = 3'b101,
    OP_WR_XFER = 3'b110,
    OP_REFRESH = 3'b111
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ROW  = 2'b01,
    ST_COL  = 2'b10
  } ram_state_t;

  localparam int          AXI_AW         = 8;
  localparam logic [7:0]  REG_STOP       = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam int          STOP_LO_LSB    = 0;
  localparam int          STOP_HI_LSB    = 8;
  localparam int          STAT_PTR_LSB   = 0;
  localparam int          STAT_DIR_BIT   = 9;
  localparam int          STAT_SPLIT_BIT = 10;
  localparam int          STAT_MODE_LSB  = 12;
  localparam int          STAT_COLOR_LSB = 16;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam int          BLK_SEL_W      = 3;

endpackage

// *** hdl/multiport_dram_port_control.sv ***
module multiport_dram_port_control #(
  parameter int ADDR_W    = 9,
  parameter int DATA_W    = 16,
  parameter int BUF_DEPTH = 512
) (
  // Clock, reset, enable
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   ce,
  // RAM port pins
  input  wire logic                   ras_n,
  input  wire logic                   cas_n,
  input  wire logic                   transfer_output_enable_n,
  input  wire logic                   write_enable_low_byte_n,
  input  wire logic                   write_enable_high_byte_n,
  input  wire logic                   special_function_select,
  input  wire logic [ADDR_W-1:0]      multiplexed_address,
  input  wire logic [DATA_W-1:0]      dq_in,
  output logic      [DATA_W-1:0]      dq_out,
  output logic                        dq_oe,
  // Serial port pins
  input  wire logic                   serial_shift_clock,
  input  wire logic                   serial_port_enable_n,
  input  wire logic [DATA_W-1:0]      serial_data_pins_in,
  output logic      [DATA_W-1:0]      serial_data_pins_out,
  output logic                        serial_data_pins_oe,
  output logic                        split_half_indicator_out,
  output logic                        split_half_indicator_oe,
  // Array engine
  output logic                        arr_go,
  output vram_pkg::op_t               arr_op,
  output logic      [ADDR_W-1:0]      arr_row,
  output logic      [ADDR_W-1:0]      arr_col,
  output logic      [DATA_W-1:0]      arr_wmask,
  output logic      [DATA_W-1:0]      arr_colmask,
  output logic      [DATA_W-1:0]      arr_wdata,
  input  wire logic [DATA_W-1:0]      arr_rdata,
  input  wire logic                   buf_we,
  input  wire logic [$clog2(BUF_DEPTH)-1:0] buf_addr,
  input  wire logic [DATA_W-1:0]      buf_wdata,
  output logic      [DATA_W-1:0]      buf_rdata,
  // AXI4-Lite slave
  input  wire logic [vram_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic      [1:0]             s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [vram_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic      [31:0]            s_axi_rdata,
  output logic      [1:0]             s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);
  import vram_pkg::*;

  localparam int PTR_W = $clog2(BUF_DEPTH);
  localparam int HLF_W = PTR_W - 1;
  localparam int PIN_W = 8 + ADDR_W + 2 * DATA_W;
  localparam int BYT_W = DATA_W / 2;

  function automatic mode_t decode_mode(input logic cas, toe, wlo, whi, sfs);
    logic wm;
    wm = ~(wlo & whi);
    if (!cas) return MD_CBR;
    if (toe) begin
      if (sfs) return wm ? MD_FWM : MD_LCR;
      return wm ? MD_RWM : MD_RW;
    end
    if (sfs) return wm ? MD_MSWT : MD_SRT;
    return wm ? MD_MWT : MD_RT;
  endfunction

  function automatic logic is_xfer(input mode_t m);
    return m inside {MD_RT, MD_SRT, MD_MWT, MD_MSWT};
  endfunction

  // Every pin is foreign to sys_clk: two flops before use
  logic [PIN_W-1:0]  meta_r, pin_r;
  logic              ras_s, cas_s, toe_s, wlo_s, whi_s, sfs_s, sck_s, spe_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] dq_s, sdq_s;
  logic [2:0]        prev_r;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      pin_r  <= '0;
      prev_r <= '0;
    end else if (ce) begin
      meta_r <= {ras_n, cas_n, transfer_output_enable_n, write_enable_low_byte_n, write_enable_high_byte_n,
                 special_function_select, serial_shift_clock, serial_port_enable_n, multiplexed_address,
                 dq_in, serial_data_pins_in};
      pin_r  <= meta_r;
      prev_r <= {ras_s, cas_s, sck_s};
    end
  end

  assign {ras_s, cas_s, toe_s, wlo_s, whi_s, sfs_s, sck_s, spe_s, addr_s, dq_s, sdq_s} = pin_r;

  logic ras_fall, cas_fall, sck_rise, we_any_low;
  assign ras_fall   = prev_r[2] & ~ras_s;
  assign cas_fall   = prev_r[1] & ~cas_s;
  assign sck_rise   = ~prev_r[0] & sck_s;
  assign we_any_low = ~(wlo_s & whi_s);

  // RAM port sequencing
  ram_state_t        state_r;
  mode_t             mode_r;
  logic [ADDR_W-1:0] row_r, col_r;
  logic [DATA_W-1:0] wmask_r, color_r;
  logic              sfs_col_r, wr_done_r;
  logic              row_open, col_start, wr_now, xfer_now;

  assign row_open  = (state_r == ST_ROW) & ~ras_s;
  assign col_start = row_open & cas_fall;
  assign xfer_now  = col_start & is_xfer(mode_r);
  // Early write at the column fall, or late write when an enable drops later
  assign wr_now    = we_any_low & ~is_xfer(mode_r) & (mode_r != MD_CBR) &
                     (col_start | ((state_r == ST_COL) & ~ras_s & ~cas_s & ~wr_done_r));

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r   <= ST_IDLE;
      mode_r    <= MD_CBR;
      row_r     <= '0;
      col_r     <= '0;
      wmask_r   <= '1;
      sfs_col_r <= 1'b0;
      wr_done_r <= 1'b0;
    end else if (ce) begin
      case (state_r)
        ST_IDLE: begin
          if (ras_fall) begin
            mode_r  <= decode_mode(cas_s, toe_s, wlo_s, whi_s, sfs_s);
            row_r   <= addr_s;
            wmask_r <= we_any_low ? dq_s : '1;
            state_r <= ST_ROW;
          end
        end
        ST_ROW: begin
          if (ras_s) begin
            state_r <= ST_IDLE;
          end else if (cas_fall) begin
            col_r     <= addr_s;
            sfs_col_r <= sfs_s;
            wr_done_r <= wr_now;
            state_r   <= ST_COL;
          end
        end
        ST_COL: begin
          if (ras_s) begin
            state_r <= ST_IDLE;
          end else if (cas_s) begin
            state_r <= ST_ROW;
          end else if (wr_now) begin
            wr_done_r <= 1'b1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Array commands; a ras-only refresh has no column and issues nothing
  logic [DATA_W-1:0] byte_mask;
  assign byte_mask = {{BYT_W{~whi_s}}, {BYT_W{~wlo_s}}};

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      arr_go      <= 1'b0;
      arr_op      <= OP_NONE;
      arr_row     <= '0;
      arr_col     <= '0;
      arr_wmask   <= '0;
      arr_colmask <= '0;
      arr_wdata   <= '0;
    end else if (ce) begin
      arr_go <= 1'b0;
      if ((state_r == ST_IDLE) & ras_fall) begin
        arr_row   <= addr_s;
        arr_wmask <= we_any_low ? dq_s : '1;
        arr_wdata <= color_r;
        if (!cas_s) begin
          arr_go <= 1'b1;
          arr_op <= OP_REFRESH;
        end else if (toe_s & sfs_s & we_any_low) begin
          arr_go <= 1'b1;
          arr_op <= OP_FLASH;
        end
      end else if (xfer_now) begin
        arr_go  <= 1'b1;
        arr_op  <= mode_r inside {MD_RT, MD_SRT} ? OP_RD_XFER : OP_WR_XFER;
        arr_col <= addr_s;
      end else if (col_start & (mode_r inside {MD_RW, MD_RWM}) & sfs_s) begin
        arr_go      <= 1'b1;
        arr_op      <= OP_BLOCK;
        arr_col     <= {addr_s[ADDR_W-1:BLK_SEL_W], {BLK_SEL_W{1'b0}}};
        arr_colmask <= dq_s;
        arr_wmask   <= wmask_r;
        arr_wdata   <= color_r;
      end else if (wr_now & (mode_r inside {MD_RW, MD_RWM}) & ~(col_start ? sfs_s : sfs_col_r)) begin
        arr_go    <= 1'b1;
        arr_op    <= OP_WRITE;
        arr_col   <= col_start ? addr_s : col_r;
        arr_wmask <= wmask_r & byte_mask;
        arr_wdata <= dq_s;
      end else if (col_start & (mode_r inside {MD_RW, MD_RWM})) begin
        arr_go  <= 1'b1;
        arr_op  <= OP_READ;
        arr_col <= addr_s;
      end
    end
  end

  // Color register and RAM data outputs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      color_r <= '0;
      dq_out  <= '0;
      dq_oe   <= 1'b0;
    end else if (ce) begin
      if (wr_now & (mode_r == MD_LCR)) color_r <= dq_s;
      dq_out <= (mode_r == MD_LCR) ? color_r : arr_rdata;
      // Column strobe and transfer output enable both low gate the outputs; read data lags arr_go by one cycle
      dq_oe  <= (state_r == ST_COL) & ~ras_s & ~cas_s & ~toe_s & ~we_any_low & ~wr_done_r & ~sfs_col_r &
                (mode_r inside {MD_RW, MD_RWM, MD_LCR});
    end
  end

  // Serial side
  logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0]  ptr_r, ptr_nxt;
  logic [HLF_W-1:0]  split_tap_r, stop_lo_r, stop_hi_r, stop_cur;
  logic              dir_out_r, split_r;

  assign stop_cur = ptr_r[PTR_W-1] ? stop_hi_r : stop_lo_r;
  // In split mode, at a half's stop address the pointer jumps to the other half's tap
  assign ptr_nxt  = (split_r & (ptr_r[HLF_W-1:0] == stop_cur)) ? {~ptr_r[PTR_W-1], split_tap_r}
                                                                 : ptr_r + 1'b1;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ptr_r       <= '0;
      split_tap_r <= '0;
      dir_out_r   <= 1'b1;
      split_r     <= 1'b0;
    end else if (ce) begin
      if (xfer_now) begin
        dir_out_r <= mode_r inside {MD_RT, MD_SRT};
        if (mode_r inside {MD_SRT, MD_MSWT}) begin
          split_r     <= 1'b1;
          split_tap_r <= addr_s[HLF_W-1:0];
        end else begin
          split_r <= 1'b0;
          ptr_r   <= addr_s[PTR_W-1:0];
        end
      end else if (sck_rise) begin
        ptr_r <= ptr_nxt;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (buf_we) begin
        buf_mem[buf_addr] <= buf_wdata;
      end else if (sck_rise & ~dir_out_r & ~spe_s) begin
        buf_mem[ptr_r] <= sdq_s;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      buf_rdata                <= '0;
      serial_data_pins_out     <= '0;
      serial_data_pins_oe      <= 1'b0;
      split_half_indicator_out <= 1'b0;
      split_half_indicator_oe  <= 1'b0;
    end else if (ce) begin
      buf_rdata                <= buf_mem[buf_addr];
      serial_data_pins_out     <= buf_mem[ptr_r];
      serial_data_pins_oe      <= dir_out_r & ~spe_s;
      split_half_indicator_out <= ptr_r[PTR_W-1];
      split_half_indicator_oe  <= ~spe_s;
    end
  end

  // AXI4-Lite slave: stop addresses and status
  logic [AXI_AW-1:0] awaddr_r;
  logic [31:0]       wdata_r, rd_word;
  logic [3:0]        wstrb_r;

  always_comb begin
    rd_word = '0;
    if (s_axi_araddr == REG_STOP) begin
      rd_word[STOP_LO_LSB +: HLF_W] = stop_lo_r;
      rd_word[STOP_HI_LSB +: HLF_W] = stop_hi_r;
    end else begin
      rd_word[STAT_PTR_LSB +: PTR_W] = ptr_r;
      rd_word[STAT_DIR_BIT]          = dir_out_r;
      rd_word[STAT_SPLIT_BIT]        = split_r;
      rd_word[STAT_MODE_LSB +: 4]    = mode_r;
      rd_word[STAT_COLOR_LSB +: DATA_W] = color_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      stop_lo_r     <= '1;
      stop_hi_r     <= '1;
    end else if (ce) begin
      if (s_axi_awvalid & s_axi_awready) begin
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (!s_axi_awready & !s_axi_wready & !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r == REG_STOP) ? RESP_OKAY : RESP_SLVERR;
        if (awaddr_r == REG_STOP) begin
          if (wstrb_r[STOP_LO_LSB / 8]) stop_lo_r <= wdata_r[STOP_LO_LSB +: HLF_W];
          if (wstrb_r[STOP_HI_LSB / 8]) stop_hi_r <= wdata_r[STOP_HI_LSB +: HLF_W];
        end
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= (s_axi_araddr inside {REG_STOP, REG_STATUS}) ? rd_word : '0;
        s_axi_rresp   <= (s_axi_araddr inside {REG_STOP, REG_STATUS}) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst || !ce);

  sequence s_row_fall;
    (state_r == ST_IDLE) && ras_fall;
  endsequence
  sequence s_early_write;
    col_start && we_any_low && (mode_r == MD_RW) && !sfs_s;
  endsequence
  sequence s_split_stop;
    split_r && sck_rise && !xfer_now && (ptr_r[HLF_W-1:0] == stop_cur);
  endsequence

  a_row_latch: assert property (s_row_fall |=> (state_r == ST_ROW) && (row_r == $past(addr_s)))
    else $error("row address not latched at row strobe fall");
  a_mode_pick: assert property (s_row_fall |=> mode_r == decode_mode($past(cas_s), $past(toe_s),
                                 $past(wlo_s), $past(whi_s), $past(sfs_s)))
    else $error("cycle mode differs from strobe levels");
  a_wpb_mask: assert property (s_row_fall ##0 we_any_low |=> wmask_r == $past(dq_s))
    else $error("write mask not taken from data pins");
  a_mask_hold: assert property ((state_r != ST_IDLE) && ($past(state_r) != ST_IDLE) |-> $stable(wmask_r))
    else $error("write mask changed within row cycle");
  a_block_cols: assert property (col_start && (mode_r == MD_RW) && sfs_s |=> arr_go && (arr_op == OP_BLOCK)
                                 && (arr_col[BLK_SEL_W-1:0] == '0) && (arr_colmask == $past(dq_s)))
    else $error("block write column or mask wrong");
  a_early_write: assert property (s_early_write |=> arr_go && (arr_op == OP_WRITE) && (arr_wmask == $past(byte_mask)))
    else $error("unmasked write not issued");
  a_ptr_step: assert property (sck_rise && !xfer_now && !split_r |=> ptr_r == $past(ptr_r) + 1'b1)
    else $error("serial pointer did not advance");
  a_split_jump: assert property (s_split_stop |=> ptr_r[PTR_W-1] != $past(ptr_r[PTR_W-1]))
    else $error("stop address did not switch halves");
  a_dir_read: assert property (xfer_now && (mode_r == MD_RT) |=> dir_out_r ##1 serial_data_pins_oe == !$past(spe_s))
    else $error("read transfer did not select output mode");
  a_flag_float: assert property (spe_s [*2] |-> !split_half_indicator_oe && !serial_data_pins_oe)
    else $error("serial outputs driven while disabled");
  a_dq_gate: assert property (dq_oe |-> $past(!cas_s && !toe_s))
    else $error("data pins driven without strobe gating");

endmodule

// *** bench/display_ctl_model.sv ***
module display_ctl_model (
  // Array engine answer
  input  wire logic [8:0]  arr_row,
  input  wire logic [8:0]  arr_col,
  output logic      [15:0] arr_rdata,
  // Serial clock and data pins
  output logic             serial_shift_clock,
  output logic      [15:0] serial_data_pins_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cells read back as a pattern of their column and row bits 6:0, so a wrong column or low row bit shows
  assign arr_rdata = {arr_row[6:0], arr_col} ^ 16'h5A00;
  initial begin
    serial_shift_clock = 1'b0;
    serial_data_pins_in = 16'hFFFF;
  end
  // Clock stands still between bursts; data flips once its hold has run out
  task automatic shift(input int n, input logic [15:0] d);
    #7;
    for (int i = 0; i < n; i++) begin
      serial_data_pins_in = d;
      #40 serial_shift_clock = 1'b1;
      #80 serial_shift_clock = 1'b0;
      #40 serial_data_pins_in = ~d;
    end
  endtask
endmodule

// *** bench/multiport_dram_port_control_bench.sv ***
module multiport_dram_port_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import vram_pkg::*;
  typedef struct packed {
    logic [4:0] pins;
    mode_t      md;
    logic       go;
    op_t        op;
  } row_case_t;
  // Bench-driven pins and bus
  logic sys_clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, ras_n = 1'b1, cas_n = 1'b1;
  logic transfer_output_enable_n = 1'b1, write_enable_low_byte_n = 1'b1, write_enable_high_byte_n = 1'b1;
  logic special_function_select = 1'b0, serial_port_enable_n = 1'b1, buf_we = 1'b0;
  logic [8:0] multiplexed_address = 9'h000, buf_addr = 9'h000;
  logic [15:0] dq_in = 16'h0000, buf_wdata = 16'h0000;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  // Design and model outputs
  logic [15:0] dq_out, serial_data_pins_out, serial_data_pins_in, arr_wmask, arr_colmask, arr_wdata, arr_rdata;
  logic [15:0] buf_rdata;
  logic dq_oe, serial_data_pins_oe, split_half_indicator_out, split_half_indicator_oe, arr_go, serial_shift_clock;
  logic [8:0] arr_row, arr_col;
  op_t arr_op;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, v;
  int bad_count = 0, samples_checked = 0, go_cnt = 0, g0;
  row_case_t cases [9];

  multiport_dram_port_control i_multiport_dram_port_control (
    .sys_clk, .sys_rst, .ce, .ras_n, .cas_n, .transfer_output_enable_n, .write_enable_low_byte_n,
    .write_enable_high_byte_n, .special_function_select, .multiplexed_address, .dq_in, .dq_out, .dq_oe,
    .serial_shift_clock, .serial_port_enable_n, .serial_data_pins_in, .serial_data_pins_out,
    .serial_data_pins_oe, .split_half_indicator_out, .split_half_indicator_oe, .arr_go, .arr_op, .arr_row,
    .arr_col, .arr_wmask, .arr_colmask, .arr_wdata, .arr_rdata, .buf_we, .buf_addr, .buf_wdata, .buf_rdata,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  display_ctl_model i_display_ctl_model (.arr_row, .arr_col, .arr_rdata, .serial_shift_clock, .serial_data_pins_in);

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (arr_go === 1'b1) go_cnt <= go_cnt + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Each channel is held until its own handshake; bready stays up until the answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] rs);
    int n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 40) bad_count++;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 40) bad_count++;
  endtask
  task automatic stat;
    axi_rd(REG_STATUS, v, r);
  endtask
  // Levels settle ahead of the strobe so the synchroniser never sees both move together
  task automatic row_fall(input logic [4:0] p, input logic [8:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    {cas_n, transfer_output_enable_n, write_enable_low_byte_n, write_enable_high_byte_n, special_function_select} <= p;
    multiplexed_address <= a;
    dq_in <= d;
    tick(4);
    ras_n <= 1'b0;
    tick(6);
  endtask
  task automatic col_fall(input logic [2:0] p, input logic [8:0] a, input logic [15:0] d, input int ng);
    @(posedge sys_clk);
    {special_function_select, write_enable_low_byte_n, write_enable_high_byte_n} <= p;
    multiplexed_address <= a;
    dq_in <= d;
    g0 = go_cnt;
    tick(4);
    cas_n <= 1'b0;
    tick(6);
    check(go_cnt - g0, ng);
  endtask
  task automatic col_rise;
    @(posedge sys_clk);
    cas_n <= 1'b1;
    tick(6);
  endtask
  task automatic cyc_end;
    @(posedge sys_clk);
    {ras_n, cas_n, transfer_output_enable_n, write_enable_low_byte_n, write_enable_high_byte_n} <= 5'h1F;
    special_function_select <= 1'b0;
    tick(6);
  endtask
  task automatic serial_pins(input logic [18:0] exp);
    check(32'({serial_data_pins_oe, split_half_indicator_oe, split_half_indicator_out, serial_data_pins_out}),
          32'(exp));
  endtask

  initial begin
    #400_000;
    bad_count++;
    summarize;
  end

  initial begin
    // Pins {cas, trg, wel, weu, dsf} at the row fall, mode code, command expected there
    cases = '{'{5'b01110, MD_CBR, 1'b1, OP_REFRESH}, '{5'b11110, MD_RW, 1'b0, OP_NONE},
              '{5'b11010, MD_RWM, 1'b0, OP_NONE}, '{5'b11001, MD_FWM, 1'b1, OP_FLASH},
              '{5'b11111, MD_LCR, 1'b0, OP_NONE}, '{5'b10110, MD_RT, 1'b0, OP_NONE},
              '{5'b10111, MD_SRT, 1'b0, OP_NONE}, '{5'b10010, MD_MWT, 1'b0, OP_NONE},
              '{5'b10101, MD_MSWT, 1'b0, OP_NONE}};
    tick(12);
    sys_rst <= 1'b0;
    stat;
    check(v, 32'h0000_0200);
    axi_rd(REG_STOP, v, r);
    check(v, 32'h0000_FFFF);
    axi_wr(REG_STOP, 32'h0000_1234, 4'h1, r);
    check(32'(r), 32'(RESP_OKAY));
    axi_rd(REG_STOP, v, r);
    check(v, 32'h0000_FF34);
    axi_wr(REG_STATUS, 32'hFFFF_FFFF, 4'hF, r);
    check(32'(r), 32'(RESP_SLVERR));
    axi_rd(8'h08, v, r);
    check({v[29:0], r}, 32'(RESP_SLVERR));
    foreach (cases[i]) begin
      g0 = go_cnt;
      row_fall(cases[i].pins, 9'(i), 16'h0000);
      stat;
      check(32'(v[15:12]), 32'(cases[i].md));
      check(go_cnt - g0, 32'(cases[i].go));
      if (cases[i].go) check(32'(arr_op), 32'(cases[i].op));
      cyc_end;
    end
    row_fall(5'b11110, 9'h1A3, 16'h0000);
    col_fall(3'b011, 9'h05C, 16'h0000, 1);
    check(32'({arr_op, arr_row, arr_col}), 32'({OP_READ, 9'h1A3, 9'h05C}));
    check(32'(dq_oe), 32'h0);
    @(posedge sys_clk);
    transfer_output_enable_n <= 1'b0;
    tick(5);
    check(32'({dq_oe, dq_out}), 32'h0001_1C5C);
    cyc_end;
    check(32'(dq_oe), 32'h0);
    // Page mode: the mask from the row fall must survive the second column access
    row_fall(5'b11010, 9'h0F0, 16'hF00F);
    col_fall(3'b001, 9'h011, 16'h1234, 1);
    check(32'({arr_op, arr_wmask}), 32'({OP_WRITE, 16'h000F}));
    col_rise;
    col_fall(3'b001, 9'h012, 16'h0000, 1);
    check(32'({arr_wmask, arr_col}), 32'({16'h000F, 9'h012}));
    cyc_end;
    row_fall(5'b11110, 9'h002, 16'h0000);
    col_fall(3'b000, 9'h003, 16'hABCD, 1);
    check(32'({arr_op, arr_wmask}), 32'({OP_WRITE, 16'hFFFF}));
    cyc_end;
    row_fall(5'b11111, 9'h004, 16'h0000);
    col_fall(3'b111, 9'h000, 16'hC3A5, 0);
    @(posedge sys_clk);
    write_enable_low_byte_n <= 1'b0;
    tick(5);
    cyc_end;
    stat;
    check(32'(v[31:16]), 32'h0000_C3A5);
    row_fall(5'b11001, 9'h005, 16'h0FF0);
    check(32'(arr_op), 32'(OP_FLASH));
    check({arr_wmask, arr_wdata}, {16'h0FF0, 16'hC3A5});
    cyc_end;
    row_fall(5'b11110, 9'h006, 16'h0000);
    col_fall(3'b100, 9'h1FF, 16'h81C3, 1);
    check(32'({arr_op, arr_colmask}), 32'({OP_BLOCK, 16'h81C3}));
    check(32'({arr_col[8:3], arr_wdata}), 32'({6'h3F, 16'hC3A5}));
    cyc_end;
    buf_put_pair();
  end

  task automatic buf_put(input logic [8:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    buf_we <= 1'b1;
    buf_addr <= a;
    buf_wdata <= d;
    @(posedge sys_clk);
    buf_we <= 1'b0;
  endtask
  task automatic buf_put_pair;
    buf_put(9'h0FF, 16'hA5A5);
    buf_put(9'h100, 16'h5A5A);
    serial_port_enable_n <= 1'b0;
    row_fall(5'b10110, 9'h033, 16'h0000);
    col_fall(3'b011, 9'h0FF, 16'h0000, 1);
    check(32'(arr_op), 32'(OP_RD_XFER));
    cyc_end;
    stat;
    check(32'(v[10:0]), 32'h0000_02FF);
    serial_pins({3'b110, 16'hA5A5});
    i_display_ctl_model.shift(1, 16'h0000);
    tick(6);
    serial_pins({3'b111, 16'h5A5A});
    @(posedge sys_clk);
    serial_port_enable_n <= 1'b1;
    i_display_ctl_model.shift(2, 16'h0000);
    tick(6);
    stat;
    check(32'(v[8:0]), 32'h0000_0102);
    check(32'({serial_data_pins_oe, split_half_indicator_oe}), 32'h0);
    row_fall(5'b10010, 9'h034, 16'hFFFF);
    col_fall(3'b011, 9'h010, 16'h0000, 1);
    check(32'(arr_op), 32'(OP_WR_XFER));
    cyc_end;
    stat;
    check(32'(v[10:0]), 32'h0000_0010);
    serial_port_enable_n <= 1'b0;
    i_display_ctl_model.shift(1, 16'hBEEF);
    tick(6);
    buf_addr <= 9'h010;
    tick(2);
    check(32'({serial_data_pins_oe, buf_rdata}), 32'h0000_BEEF);
    summarize;
  endtask
endmodule
